// ===== logic/lpc_target_defines.vh
// constants for the lpc byte-cycle target
`ifndef LPC_TARGET_DEFINES_VH
`define LPC_TARGET_DEFINES_VH
`define START_NIB 4'h0
`define CTYPE_MEM 2'h1
`define TAR_NIB 4'hF
`define SHORT_WAIT_NIB 4'h5
`define READY_NIB 4'h0
`define ACK_NIB 4'h0
`define ADDR_NIBS 4'h8
`define WAIT_CNT 2'h2
`define SEL_BIT 22
`endif

// ===== logic/lad_sync.v
// two-stage synchroniser for the lad and frame pins
`timescale 1ns/100ps
`default_nettype none
module lad_sync
(
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // raw pins
  input wire [3:0] lad_pin,
  input wire frame_b_pin,
  // synchronised
  output reg [3:0] lad_s,
  output reg frame_b_s
);
  reg [3:0] lad_m_q;
  reg frame_b_m_q;

  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      lad_m_q <= 4'hF;
      frame_b_m_q <= 1'b1;
      lad_s <= 4'hF;
      frame_b_s <= 1'b1;
    end
    else
    begin
      lad_m_q <= lad_pin;
      frame_b_m_q <= frame_b_pin;
      lad_s <= lad_m_q;
      frame_b_s <= frame_b_m_q;
    end
  end
endmodule // lad_sync
`default_nettype wire

// ===== logic/lpc_target.v
// lpc target: single-byte memory/register read and write cycles
// Summary of operation
// - frame low with lad 0000 marks start of a new cycle
// - type nibble bits 3:2 = 01; bit 1 direction; bit 0 ignored
// - eight address nibbles follow, most significant first, form 32 bits
// - address bit 22 picks memory array (1) or registers (0)
// - device takes lad in the clock after host turnaround
// - read: device drives short wait sync 0101 for two clocks
// - read: ready sync 0000 for one clock before data
// - read: data byte over two clocks, low nibble first
// - read: device turnaround 1111 then floats lad
// - write: data byte over two clocks after address, low first
// - write: device acknowledges with sync 0000 for one clock
// - write: device turnaround 1111 then floats lad
// - read transfers exactly one byte
`timescale 1ns/100ps
`default_nettype none
`include "lpc_target_defines.vh"
module lpc_target
(
  // clock and reset
  input wire core_clk,
  input wire rst_b,
  // lpc pins, lad is two-way
  input wire [3:0] lad_in,
  output reg [3:0] lad_out,
  output reg lad_oe,
  input wire lframe_b,
  // memory array side
  output reg mem_rd,
  output reg mem_wr,
  // register side
  output reg reg_rd,
  output reg reg_wr,
  output reg [31:0] addr_q,
  output reg [7:0] wdata_q,
  input wire [7:0] rdata
);
  localparam S_IDLE = 4'h0;
  localparam S_TYPE = 4'h1;
  localparam S_ADDR = 4'h2;
  localparam S_WDAT = 4'h3;
  localparam S_HTAR = 4'h4;
  localparam S_TAKE = 4'h5;
  localparam S_WAIT = 4'h6;
  localparam S_RDY = 4'h7;
  localparam S_DLO = 4'h8;
  localparam S_DHI = 4'h9;
  localparam S_ACK = 4'hA;
  localparam S_DTAR = 4'hB;

  wire [3:0] lad_s;
  wire frame_b_s;
  reg [3:0] state_q;
  reg [3:0] cnt_q;
  reg dir_wr_q;
  reg wlo_q;
  reg [7:0] rbyte_q;

  lad_sync u_sync
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .lad_pin(lad_in),
    .frame_b_pin(lframe_b),
    .lad_s(lad_s),
    .frame_b_s(frame_b_s)
  );

  // array or register target, picked by one address bit
  function sel_mem;
    input [31:0] a;
    begin
      sel_mem = a[`SEL_BIT];
    end
  endfunction

  // memory cycle when type bits 3:2 match; bit 0 is don't care
  function type_ok;
    input [3:0] t;
    begin
      type_ok = (t[3:2] == `CTYPE_MEM);
    end
  endfunction

  // last wait clock; the first wait nibble leaves from the take state
  function wait_done;
    input [3:0] c;
    begin
      wait_done = (c >= {2'b00, `WAIT_CNT} - 4'h1);
    end
  endfunction

  // strobe triggers: read at host turnaround, write at the acknowledge
  wire go_rd;
  wire go_wr;
  assign go_rd = frame_b_s && (state_q == S_HTAR) && !dir_wr_q;
  assign go_wr = frame_b_s && (state_q == S_TAKE) && dir_wr_q;

  // sequencer: follows the host fields and counts nibbles
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      dir_wr_q <= 1'b0;
      wlo_q <= 1'b0;
      rbyte_q <= 8'h00;
      addr_q <= 32'h00000000;
      wdata_q <= 8'h00;
    end
    else if (!frame_b_s)
    begin
      // frame low aborts anything and may start anew
      if (lad_s == `START_NIB)
        state_q <= S_TYPE;
      else
        state_q <= S_IDLE;
    end
    else
    begin
      case (state_q)
        S_IDLE:
        begin
          // wait for the next start; stray nibbles are ignored
          state_q <= S_IDLE;
        end
        S_TYPE:
        begin
          if (type_ok(lad_s))
          begin
            dir_wr_q <= lad_s[1];
            cnt_q <= 4'h0;
            state_q <= S_ADDR;
          end
          else
            state_q <= S_IDLE;
        end
        S_ADDR:
        begin
          addr_q <= {addr_q[27:0], lad_s};
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q == `ADDR_NIBS - 4'h1)
          begin
            wlo_q <= 1'b1;
            state_q <= dir_wr_q ? S_WDAT : S_HTAR;
          end
        end
        S_WDAT:
        begin
          // low nibble arrives first
          if (wlo_q)
          begin
            wdata_q[3:0] <= lad_s;
            wlo_q <= 1'b0;
          end
          else
          begin
            wdata_q[7:4] <= lad_s;
            state_q <= S_HTAR;
          end
        end
        S_HTAR:
        begin
          // host turnaround clock; lad not yet ours
          state_q <= S_TAKE;
        end
        S_TAKE:
        begin
          // the first wait or the acknowledge goes out now
          cnt_q <= 4'h1;
          state_q <= dir_wr_q ? S_ACK : S_WAIT;
        end
        S_WAIT:
        begin
          // rdata is taken two clocks after the read strobe
          rbyte_q <= rdata;
          cnt_q <= cnt_q + 4'h1;
          if (wait_done(cnt_q))
            state_q <= S_RDY;
        end
        S_RDY:
        begin
          state_q <= S_DLO;
        end
        S_DLO:
        begin
          state_q <= S_DHI;
        end
        S_DHI:
        begin
          // one byte only, no repeat of the data pair
          state_q <= S_ACK;
        end
        S_ACK:
        begin
          state_q <= S_DTAR;
        end
        S_DTAR:
        begin
          state_q <= S_IDLE;
        end
        default:
        begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // lad driver: registered, one nibble per clock while we own lad
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      lad_out <= `TAR_NIB;
      lad_oe <= 1'b0;
    end
    else if (!frame_b_s)
    begin
      // host owns lad whenever frame is low
      lad_oe <= 1'b0;
      lad_out <= `TAR_NIB;
    end
    else
    begin
      case (state_q)
        S_TAKE:
        begin
          // ownership taken, first driven nibble follows
          lad_oe <= 1'b1;
          if (dir_wr_q)
            lad_out <= `ACK_NIB;
          else
            lad_out <= `SHORT_WAIT_NIB;
        end
        S_WAIT:
        begin
          lad_oe <= 1'b1;
          lad_out <= `SHORT_WAIT_NIB;
        end
        S_RDY:
        begin
          lad_oe <= 1'b1;
          lad_out <= `READY_NIB;
        end
        S_DLO:
        begin
          lad_oe <= 1'b1;
          lad_out <= rbyte_q[3:0];
        end
        S_DHI:
        begin
          lad_oe <= 1'b1;
          lad_out <= rbyte_q[7:4];
        end
        S_ACK:
        begin
          lad_oe <= 1'b1;
          lad_out <= `TAR_NIB;
        end
        S_DTAR:
        begin
          // bus handed back; out rests at the turnaround value
          lad_oe <= 1'b0;
          lad_out <= `TAR_NIB;
        end
        default:
        begin
          // idle and host-driven fields: never drive lad
          lad_oe <= 1'b0;
          lad_out <= `TAR_NIB;
        end
      endcase
    end
  end

  // access strobes, one clock each, to the array or the registers
  always @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_wr <= 1'b0;
    end
    else
    begin
      // rdata must be steady from here until the last wait clock
      mem_rd <= go_rd && sel_mem(addr_q);
      reg_rd <= go_rd && !sel_mem(addr_q);
      mem_wr <= go_wr && sel_mem(addr_q);
      reg_wr <= go_wr && !sel_mem(addr_q);
    end
  end
endmodule // lpc_target
`default_nettype wire

// ===== tb/lpc_target_props.sv
// assertions for the lpc byte-cycle target
`timescale 1ns/100ps
`default_nettype none
module lpc_target_props
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // lad side
  input wire logic [3:0] lad_out,
  input wire logic lad_oe,
  // access side
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [31:0] addr_q,
  input wire logic [7:0] rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence rd_on;
    $rose(lad_oe) && lad_out == 4'h5;
  endsequence
  sequence wr_on;
    $rose(lad_oe) && lad_out == 4'h0;
  endsequence
  wait_twice_a: assert property
    (rd_on |=> lad_out == 4'h5 ##1 lad_out == 4'h0) else $error("wait");
  read_data_a: assert property
    (rd_on |-> ##3 lad_out == rdata[3:0] ##1 lad_out == rdata[7:4])
    else $error("data");
  read_end_a: assert property
    (rd_on |-> ##5 lad_oe && lad_out == 4'hF ##1 !lad_oe) else $error("rend");
  write_end_a: assert property
    (wr_on |=> lad_oe && lad_out == 4'hF ##1 !lad_oe) else $error("wend");
  wr_at_ack_a: assert property
    (mem_wr || reg_wr |-> wr_on) else $error("ack");
  rd_take_a: assert property
    (mem_rd || reg_rd |=> rd_on) else $error("take");
  mem_sel_a: assert property
    (mem_rd || mem_wr |-> addr_q[22]) else $error("mem");
  reg_sel_a: assert property
    (reg_rd || reg_wr |-> !addr_q[22]) else $error("reg");
  cover property (mem_rd);
  cover property (reg_wr);
  cover property (rd_on);
  cover property (wr_on);
endmodule // lpc_target_props
bind lpc_target lpc_target_props u_props (.core_clk(core_clk),
  .rst_b(rst_b), .lad_out(lad_out), .lad_oe(lad_oe), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .reg_rd(reg_rd), .reg_wr(reg_wr), .addr_q(addr_q),
  .rdata(rdata));
`default_nettype wire

// ===== tb/lpc_host.sv
// lpc host model driving single-byte cycles
`timescale 1ns/100ps
`default_nettype none
module lpc_host
(
  // bus clock
  input wire logic core_clk,
  // host side of lad and frame
  output logic h_oe,
  output logic [3:0] h_nib,
  output logic lframe_b
);
  initial {h_oe, h_nib, lframe_b} = 6'h1F;
  task put(input [3:0] n);
    @(posedge core_clk) #1 h_nib = n;
  endtask
  // a frame whose start nibble is not zero, then a plausible read
  task junk(input [3:0] s);
    @(posedge core_clk) #1 {h_oe, lframe_b, h_nib} = {2'b10, s};
    @(posedge core_clk) #1 {lframe_b, h_nib} = 5'h14;
    repeat (10) put(4'hF);
    @(posedge core_clk) #1 h_oe = 0;
  endtask
  task run(input [3:0] t, input [31:0] a, input [7:0] d);
    integer i;
    @(posedge core_clk) #1 {h_oe, lframe_b, h_nib} = 6'h20;
    @(posedge core_clk) #1 {lframe_b, h_nib} = {1'b1, t};
    for (i = 7; i >= 0; i--) put(a[4*i+:4]);
    if (t[1])
    begin
      put(d[3:0]);
      put(d[7:4]);
    end
    put(4'hF);
    // released lines fall back to the pull-up level
    @(posedge core_clk) #1 h_oe = 0;
  endtask
endmodule // lpc_host
`default_nettype wire

// ===== tb/lpc_target_bench.sv
// bench for the lpc byte-cycle target
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module lpc_target_bench;
  logic core_clk = 0;
  logic rst_b = 0;
  logic [7:0] rdata = 8'h00;
  logic [3:0] strb;
  wire h_oe, lframe_b, lad_oe, mem_rd, mem_wr, reg_rd, reg_wr;
  wire [3:0] h_nib, lad_out;
  wire [31:0] addr_q;
  wire [7:0] wdata_q;
  // pulled-up wire: whoever enables drives it
  wire [3:0] lad_in = lad_oe ? lad_out : h_oe ? h_nib : 4'hF;
  integer err_count = 0;
  integer n_checks = 0;
  always #20 core_clk = ~core_clk;
  lpc_host u_host (.core_clk(core_clk), .h_oe(h_oe), .h_nib(h_nib),
    .lframe_b(lframe_b));
  lpc_target u_dut (.core_clk(core_clk), .rst_b(rst_b), .lad_in(lad_in),
    .lad_out(lad_out), .lad_oe(lad_oe), .lframe_b(lframe_b),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .addr_q(addr_q), .wdata_q(wdata_q), .rdata(rdata));
  task xfer(input [3:0] t, input [31:0] a, input [7:0] d, input [3:0] s);
    integer i;
    logic [23:0] e;
    e = t[1] ? 24'hF0 : {4'hF, d, 12'h055};
    strb = 0;
    rdata = d;
    u_host.run(t, a, d);
    for (i = 0; i < 12 && lad_oe !== 1'b1; i++)
    begin
      @(negedge core_clk);
      strb = strb | {mem_rd, mem_wr, reg_rd, reg_wr};
    end
    if (s == 0)
    begin
      `CHK("idle", 1'b0, lad_oe)
      `CHK("idle strobe", 4'h0, strb)
      return;
    end
    for (i = 0; i < (t[1] ? 2 : 6); i++)
    begin
      `CHK("lad", {1'b1, e[4*i+:4]}, {lad_oe, lad_out})
      @(negedge core_clk);
    end
    `CHK("float", 1'b0, lad_oe)
    `CHK("strobe", s, strb)
    `CHK("addr", a, addr_q)
    if (t[1]) `CHK("wdata", d, wdata_q)
  endtask
  task t_read;
    xfer(4'h4, 32'hFFC0_1234, 8'hA5, 4'h8);
    xfer(4'h5, 32'hFFFF_FFFE, 8'h3C, 4'h8);
    $display("test read done");
  endtask
  task t_write;
    xfer(4'h6, 32'hFF80_0010, 8'h3C, 4'h1);
    xfer(4'h7, 32'hFFBF_FFFF, 8'hC3, 4'h1);
    $display("test write done");
  endtask
  task t_back;
    xfer(4'h4, 32'hFF80_0002, 8'h5A, 4'h2);
    xfer(4'h6, 32'hFFFF_FFFF, 8'h96, 4'h4);
    $display("test back done");
  endtask
  task t_refuse;
    xfer(4'h8, 32'hFFC0_0000, 8'h11, 4'h0);
    xfer(4'hC, 32'hFFC0_0000, 8'h11, 4'h0);
    xfer(4'h4, 32'hFFC0_0001, 8'h69, 4'h8);
    $display("test refuse done");
  endtask
  task t_junk;
    integer i;
    strb = 0;
    u_host.junk(4'h5);
    for (i = 0; i < 12; i++)
    begin
      @(negedge core_clk);
      strb = strb | {mem_rd, mem_wr, reg_rd, reg_wr};
      `CHK("junk oe", 1'b0, lad_oe)
    end
    `CHK("junk strobe", 4'h0, strb)
    $display("test junk done");
  endtask
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    #1 rst_b = 1;
    repeat (3) @(posedge core_clk);
    t_read;
    t_write;
    t_back;
    t_refuse;
    t_junk;
    summarize;
  end
  initial
  begin
    #200000;
    err_count++;
    summarize;
  end
endmodule // lpc_target_bench
`default_nettype wire
